/* asp_defs.vh */
// register map, field positions and reset values of the serial port
`ifndef ASP_DEFS_VH
`define ASP_DEFS_VH
// register addresses
`define ASP_A_MODE 4'h0
`define ASP_A_STAT 4'h2
`define ASP_A_BRGC 4'h4
`define ASP_A_BSRC 4'h6
`define ASP_A_TXD 4'h8
`define ASP_A_RXB 4'ha
// mode register fields
`define ASP_M_TXE 7
`define ASP_M_RXE 6
`define ASP_M_PARH 5
`define ASP_M_PARL 4
`define ASP_M_LEN 3
`define ASP_M_STOP 2
`define ASP_M_SUPP 1
`define ASP_MODE_WMASK 8'hfe
// status register fields
`define ASP_S_PE 2
`define ASP_S_FE 1
`define ASP_S_OVE 0
// baud source register fields
`define ASP_B_EXT 0
`define ASP_B_PSH 3
`define ASP_B_PSL 1
// parity codes
`define ASP_PAR_NONE 2'h0
`define ASP_PAR_ZERO 2'h1
`define ASP_PAR_ODD 2'h2
`define ASP_PAR_EVEN 2'h3
// reset values
`define ASP_MODE_RST 8'h00
`define ASP_STAT_RST 3'h0
`define ASP_BRGC_RST 8'h00
`define ASP_BSRC_RST 4'h0
`define ASP_DATA_RST 8'hff
// oversampling: 16 ticks per bit, centre at tick 7 of the start bit
`define ASP_OVS_LAST 4'hf
`define ASP_OVS_HALF 4'h7
`define ASP_BRGC_MIN 8'h08
// frame sizes
`define ASP_FRM_W 12
`define ASP_FRM_ONES 12'hfff
`define ASP_BITS8 4'h8
`define ASP_BITS7 4'h7
`endif

/* asp_baud_gen.v */
// oversampling baud tick from the internal or external clock source
`timescale 1ns/1ns
`include "asp_defs.vh"
module asp_baud_gen (
  // clock and reset
  input wire core_clk,
  input wire rst_n,
  // configuration
  input wire enable,
  input wire useExt,
  input wire [2:0] prescale,
  input wire [7:0] divisor,
  input wire extClk,
  // tick out
  output reg tick16_r
);
  reg [7:0] preCnt_r;
  reg [7:0] divCnt_r;
  reg extPrev_r;
  wire [7:0] preMask = (8'h01 << prescale) - 8'h01;
  wire intTick = (preCnt_r & preMask) == preMask;
  wire extTick = extClk & ~extPrev_r;
  wire srcTick = useExt ? extTick : intTick;
  // divisors below the minimum are not allowed; they give no ticks
  wire divOk = divisor >= `ASP_BRGC_MIN;
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      preCnt_r <= 8'h00;
      divCnt_r <= 8'h00;
      extPrev_r <= 1'b0;
      tick16_r <= 1'b0;
    end else begin
      extPrev_r <= extClk;
      tick16_r <= 1'b0;
      if (!enable || !divOk) begin
        preCnt_r <= 8'h00;
        divCnt_r <= 8'h00;
      end else begin
        preCnt_r <= preCnt_r + 8'h01;
        if (srcTick) begin
          // 10 MHz, divisor 20 gives 16 x 31.25 kbps
          if (divCnt_r >= divisor - 8'h01) begin
            divCnt_r <= 8'h00;
            tick16_r <= 1'b1;
          end else begin
            divCnt_r <= divCnt_r + 8'h01;
          end
        end
      end
    end
  end
endmodule // asp_baud_gen

/* asp_tx.v */
// transmit framer and shifter
`timescale 1ns/1ns
`include "asp_defs.vh"
module asp_tx (
  // clock and reset
  input wire core_clk,
  input wire rst_n,
  // control
  input wire enable,
  input wire tick16,
  input wire start,
  input wire [7:0] data,
  input wire len8,
  input wire [1:0] parity,
  input wire stop2,
  // line and state
  output reg txOut_r,
  output reg busy_r
);
  reg [`ASP_FRM_W-1:0] frame;
  reg [`ASP_FRM_W-1:0] shift_r;
  reg [3:0] bitsLeft_r;
  reg [3:0] tickCnt_r;
  reg [3:0] nData;
  reg parBit;
  reg [3:0] nBits;
  integer i;
  always @* begin
    nData = len8 ? `ASP_BITS8 : `ASP_BITS7;
    parBit = ^(data & {len8, 7'h7f});
    if (parity == `ASP_PAR_ODD)
      parBit = ~parBit;
    else if (parity == `ASP_PAR_ZERO)
      parBit = 1'b0;
    frame = `ASP_FRM_ONES;
    frame[0] = 1'b0;
    for (i = 0; i < 8; i = i + 1) begin
      if (i < nData)
        frame[i + 1] = data[i];
    end
    if (parity != `ASP_PAR_NONE)
      frame[nData + 4'h1] = parBit;
    nBits = nData + 4'h1 + {3'h0, parity != `ASP_PAR_NONE} +
      (stop2 ? 4'h2 : 4'h1);
  end
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      txOut_r <= 1'b1;
      busy_r <= 1'b0;
      shift_r <= `ASP_FRM_ONES;
      bitsLeft_r <= 4'h0;
      tickCnt_r <= 4'h0;
    end else if (!enable) begin
      txOut_r <= 1'b1;
      busy_r <= 1'b0;
    end else if (start && !busy_r) begin
      txOut_r <= frame[0];
      shift_r <= frame >> 1;
      bitsLeft_r <= nBits - 4'h1;
      tickCnt_r <= 4'h0;
      busy_r <= 1'b1;
    end else if (busy_r && tick16) begin
      tickCnt_r <= tickCnt_r + 4'h1;
      if (tickCnt_r == `ASP_OVS_LAST) begin
        if (bitsLeft_r == 4'h0) begin
          busy_r <= 1'b0;
          txOut_r <= 1'b1;
        end else begin
          txOut_r <= shift_r[0];
          shift_r <= {1'b1, shift_r[`ASP_FRM_W-1:1]};
          bitsLeft_r <= bitsLeft_r - 4'h1;
        end
      end
    end
  end
endmodule // asp_tx

/* asp_serial_port.v */
// asynchronous serial port: registers, receiver and pin control
// Function
// - stopped mode halts all serial transfer
// - full duplex, data byte after start bit
// - baud from internal clock or external pin
// - baud generator reaches 31.25 kbps
// - transmit data write starts transmission
// - seven-bit mode sends low seven bits
// - transmit data write only, reads zero
// - transmit data resets to all ones
// - shifter fills, full character goes to buffer
// - receive shifter hidden from software
// - seven-bit receive clears buffer top bit
// - receive buffer read only, resets ones
// - frame: start, optional parity, stop bits
// - receiver records error type in status
// - parity none, zero, odd or even
// - 7/8 bits, 1/2 stops, one checked
// - flags parity, framing and overrun errors
// - completion pulse suppressible on error
//
// Design decisions made here: the placing of the registers and the strobed register port.
`timescale 1ns/1ns
`include "asp_defs.vh"
module asp_serial_port (
  // clock and reset
  input wire core_clk,
  input wire rst_n,
  // register port
  input wire [3:0] busAddr,
  input wire [7:0] busWrData,
  input wire busWrEn,
  input wire busRdEn,
  output reg [7:0] busRdData_r,
  // serial pins
  input wire serialInPin,
  input wire externalBaudClockPin,
  output wire serialOutPin,
  // events and state
  output reg rxDone_r,
  output reg rxErr_r,
  output wire txBusy
);
  localparam [4:0] ST_IDLE = 5'b00001;
  localparam [4:0] ST_START = 5'b00010;
  localparam [4:0] ST_DATA = 5'b00100;
  localparam [4:0] ST_PAR = 5'b01000;
  localparam [4:0] ST_STOP = 5'b10000;

  // software visible registers, transmit start pulse and receive full flag
  reg [7:0] serialMode_r;
  reg [2:0] errStatus_r;
  reg [7:0] baudDivider_r;
  reg [3:0] baudSource_r;
  reg [7:0] transmitData_r;
  reg [7:0] receiveDataBuffer_r;
  reg txStart_r;
  reg rxFull_r;

  // receiver state
  reg [4:0] rxState_r;
  reg [3:0] rxTicks_r;
  reg [3:0] rxBit_r;
  reg [7:0] receiveShifter_r;
  reg rxParBit_r;
  reg rxIn_r;
  reg rxPrev_r;

  wire txEnable = serialMode_r[`ASP_M_TXE];
  wire rxEnable = serialMode_r[`ASP_M_RXE];
  wire [1:0] paritySelect =
    serialMode_r[`ASP_M_PARH:`ASP_M_PARL];
  wire charLengthSelect = serialMode_r[`ASP_M_LEN];
  wire stopLengthSelect = serialMode_r[`ASP_M_STOP];
  wire errorIrqSuppress = serialMode_r[`ASP_M_SUPP];
  wire baudTick;

  wire wrMode = busWrEn && busAddr == `ASP_A_MODE;
  wire wrBrgc = busWrEn && busAddr == `ASP_A_BRGC;
  wire wrBsrc = busWrEn && busAddr == `ASP_A_BSRC;
  wire wrTxd = busWrEn && busAddr == `ASP_A_TXD;
  wire rdStat = busRdEn && busAddr == `ASP_A_STAT;
  wire rdRxb = busRdEn && busAddr == `ASP_A_RXB;

  // last data bit index: 6 or 7
  wire [3:0] lastBit = charLengthSelect ?
    (`ASP_BITS8 - 4'h1) : (`ASP_BITS7 - 4'h1);
  wire parityOn = paritySelect != `ASP_PAR_NONE;
  wire bitEnd = baudTick && rxTicks_r == `ASP_OVS_LAST;
  wire startMid = baudTick && rxTicks_r == `ASP_OVS_HALF;
  wire rxComplete = rxState_r == ST_STOP && bitEnd;

  // parity check of the received character
  wire rxParSum = ^receiveShifter_r ^ rxParBit_r;
  wire parErr = (paritySelect == `ASP_PAR_ODD && !rxParSum) ||
    (paritySelect == `ASP_PAR_EVEN && rxParSum);
  wire frmErr = !rxIn_r;
  wire ovrErr = rxFull_r;
  wire anyErr = parErr || frmErr || ovrErr;

  // baud generator; idles in stopped mode to save power
  asp_baud_gen u_baud (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .enable(txEnable || rxEnable),
    .useExt(baudSource_r[`ASP_B_EXT]),
    .prescale(baudSource_r[`ASP_B_PSH:`ASP_B_PSL]),
    .divisor(baudDivider_r),
    .extClk(externalBaudClockPin),
    .tick16_r(baudTick)
  );

  // transmitter runs beside the receiver
  asp_tx u_tx (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .enable(txEnable),
    .tick16(baudTick),
    .start(txStart_r),
    .data(transmitData_r),
    .len8(charLengthSelect),
    .parity(paritySelect),
    .stop2(stopLengthSelect),
    .txOut_r(serialOutPin),
    .busy_r(txBusy)
  );

  // configuration registers
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      serialMode_r <= `ASP_MODE_RST;
      baudDivider_r <= `ASP_BRGC_RST;
      baudSource_r <= `ASP_BSRC_RST;
    end else begin
      if (wrMode)
        serialMode_r <= busWrData & `ASP_MODE_WMASK;
      if (wrBrgc)
        baudDivider_r <= busWrData;
      if (wrBsrc)
        baudSource_r <= busWrData[3:0];
    end
  end

  // transmit data; a write during a frame is dropped by the shifter
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      transmitData_r <= `ASP_DATA_RST;
      txStart_r <= 1'b0;
    end else begin
      txStart_r <= wrTxd && txEnable;
      if (wrTxd)
        transmitData_r <= busWrData;
    end
  end

  // read data stands one cycle after the read strobe
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      busRdData_r <= 8'h00;
    end else if (busRdEn) begin
      case (busAddr)
        `ASP_A_MODE: busRdData_r <= serialMode_r;
        `ASP_A_STAT: busRdData_r <= {5'h00, errStatus_r};
        `ASP_A_BRGC: busRdData_r <= baudDivider_r;
        `ASP_A_BSRC: busRdData_r <= {4'h0, baudSource_r};
        `ASP_A_RXB: busRdData_r <= receiveDataBuffer_r;
        `ASP_A_TXD: busRdData_r <= 8'h00;
        default: busRdData_r <= 8'h00;
      endcase
    end else begin
      busRdData_r <= 8'h00;
    end
  end

  // receive pin sampling for edge detection
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rxIn_r <= 1'b1;
      rxPrev_r <= 1'b1;
    end else begin
      rxIn_r <= serialInPin;
      rxPrev_r <= rxIn_r;
    end
  end

  // receiver state machine
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rxState_r <= ST_IDLE;
      rxTicks_r <= 4'h0;
      rxBit_r <= 4'h0;
      receiveShifter_r <= 8'h00;
      rxParBit_r <= 1'b0;
    end else if (!rxEnable) begin
      rxState_r <= ST_IDLE;
      rxTicks_r <= 4'h0;
    end else begin
      if (baudTick)
        rxTicks_r <= rxTicks_r + 4'h1;
      case (rxState_r)
        ST_IDLE: begin
          rxTicks_r <= 4'h0;
          if (rxPrev_r && !rxIn_r) begin
            rxState_r <= ST_START;
            receiveShifter_r <= 8'h00;
          end
        end
        ST_START: begin
          if (startMid) begin
            rxTicks_r <= 4'h0;
            rxBit_r <= 4'h0;
            // a glitch shorter than half a bit is not a start
            if (rxIn_r)
              rxState_r <= ST_IDLE;
            else
              rxState_r <= ST_DATA;
          end
        end
        ST_DATA: begin
          if (bitEnd) begin
            receiveShifter_r[rxBit_r[2:0]] <= rxIn_r;
            rxBit_r <= rxBit_r + 4'h1;
            if (rxBit_r == lastBit)
              rxState_r <= parityOn ? ST_PAR : ST_STOP;
          end
        end
        ST_PAR: begin
          if (bitEnd) begin
            rxParBit_r <= rxIn_r;
            rxState_r <= ST_STOP;
          end
        end
        ST_STOP: begin
          // only the first stop bit is checked
          if (bitEnd)
            rxState_r <= ST_IDLE;
        end
        default: rxState_r <= ST_IDLE;
      endcase
    end
  end

  // receive buffer, full flag and error status
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      receiveDataBuffer_r <= `ASP_DATA_RST;
      rxFull_r <= 1'b0;
      errStatus_r <= `ASP_STAT_RST;
    end else begin
      // a status read clears; a new error in that cycle wins
      if (rdStat)
        errStatus_r <= `ASP_STAT_RST;
      if (rdRxb)
        rxFull_r <= 1'b0;
      if (rxComplete) begin
        receiveDataBuffer_r <= receiveShifter_r;
        rxFull_r <= 1'b1;
        errStatus_r <= {parErr, frmErr, ovrErr};
      end
    end
  end

  // completion and error pulses
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rxDone_r <= 1'b0;
      rxErr_r <= 1'b0;
    end else begin
      rxDone_r <= rxComplete &&
        !(errorIrqSuppress && anyErr);
      rxErr_r <= rxComplete && anyErr;
    end
  end
endmodule // asp_serial_port

/* asp_serial_port_checker.sv */
// assertions on the serial port pins and register port
`timescale 1ns/1ns
module asp_serial_port_checker (
  // clock and reset
  input wire core_clk,
  input wire rst_n,
  // register port
  input wire [3:0] busAddr,
  input wire busWrEn,
  input wire busRdEn,
  input wire [7:0] busRdData_r,
  // serial and events
  input wire serialOutPin,
  input wire rxDone_r,
  input wire rxErr_r,
  input wire txBusy
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  property p_rdIdle;
    !busRdEn |=> busRdData_r == 8'h00;
  endproperty
  property p_txRd;
    busRdEn && busAddr == 4'h8 |=> busRdData_r == 8'h00;
  endproperty
  property p_hide;
    busRdEn && busAddr == 4'hc |=> busRdData_r == 8'h00;
  endproperty
  property p_stat;
    busRdEn && busAddr == 4'h2 |=> busRdData_r[7:3] == 5'h00;
  endproperty
  property p_idle;
    !txBusy |-> serialOutPin;
  endproperty
  property p_start;
    $rose(txBusy) |-> !serialOutPin;
  endproperty
  // start lags the write by two samples; the check also allows three
  property p_launch;
    $rose(txBusy) |-> $past(busWrEn && busAddr == 4'h8, 2)
      || $past(busWrEn && busAddr == 4'h8, 3);
  endproperty
  property p_done;
    rxDone_r |=> !rxDone_r;
  endproperty
  property p_err;
    rxErr_r |=> !rxErr_r;
  endproperty
  property p_stop;
    $fell(txBusy) |-> $past(serialOutPin);
  endproperty
  a_rdIdle: assert property (p_rdIdle) else $error("read data not idle");
  a_txRd: assert property (p_txRd) else $error("tx data readable");
  a_hide: assert property (p_hide) else $error("hidden addr read");
  a_stat: assert property (p_stat) else $error("status top bits");
  a_idle: assert property (p_idle) else $error("line not idle");
  a_start: assert property (p_start) else $error("no start bit");
  a_launch: assert property (p_launch) else $error("tx no write");
  a_done: assert property (p_done) else $error("done too long");
  a_err: assert property (p_err) else $error("error too long");
  a_stop: assert property (p_stop) else $error("stop not high");
  c_done: cover property (rxDone_r);
  c_err: cover property (rxErr_r);
  c_tx: cover property ($rose(txBusy));
endmodule // asp_serial_port_checker

bind asp_serial_port asp_serial_port_checker chk (.core_clk(core_clk),
  .rst_n(rst_n), .busAddr(busAddr), .busWrEn(busWrEn), .busRdEn(busRdEn),
  .busRdData_r(busRdData_r), .serialOutPin(serialOutPin),
  .rxDone_r(rxDone_r), .rxErr_r(rxErr_r), .txBusy(txBusy));

/* asp_remote.sv */
// remote serial device: sends frames, captures transmitted ones
`timescale 1ns/1ns
module asp_remote #(
  parameter int BIT = 128
) (
  // clock
  input wire core_clk,
  // serial lines
  input wire lineIn,
  output logic lineOut
);
  logic [11:0] rxQ[$];
  logic [11:0] f;
  // bit length in clocks; the bench changes it for the slow source
  int bitLen = BIT;
  initial lineOut = 1'b1;
  // twelve bit times, lsb first; tail bits are idle ones, so the line
  // is left high without a second drive in the same step
  task automatic send(input logic [11:0] fr);
    for (int i = 0; i < 12; i++) begin
      lineOut <= fr[i];
      repeat (bitLen) @(posedge core_clk);
    end
  endtask
  // centre sampling; bits after the stops read as idle
  always begin
    @(negedge lineIn);
    repeat (bitLen / 2) @(posedge core_clk);
    for (int i = 0; i < 12; i++) begin
      f[i] = lineIn;
      repeat (bitLen) @(posedge core_clk);
    end
    rxQ.push_back(f);
  end
endmodule // asp_remote

/* asp_serial_port_tb.sv */
// bench for the serial port with a behavioural frame model
`timescale 1ns/1ns
module asp_serial_port_tb;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] busAddr = 4'h0;
  logic [7:0] busWrData = 8'h00;
  logic busWrEn = 1'b0;
  logic busRdEn = 1'b0;
  logic [7:0] busRdData_r;
  logic serialInPin;
  logic serialOutPin;
  logic rxDone_r;
  logic rxErr_r;
  logic txBusy;
  logic extClk = 1'b0;
  logic evDone;
  logic evErr;
  logic [7:0] rv;
  logic [11:0] fr;
  int mismatches = 0;
  int n_tests = 0;
  asp_serial_port uut (.core_clk(core_clk), .rst_n(rst_n),
    .busAddr(busAddr), .busWrData(busWrData), .busWrEn(busWrEn),
    .busRdEn(busRdEn), .busRdData_r(busRdData_r),
    .serialInPin(serialInPin), .externalBaudClockPin(extClk),
    .serialOutPin(serialOutPin), .rxDone_r(rxDone_r),
    .rxErr_r(rxErr_r), .txBusy(txBusy));
  asp_remote rem (.core_clk(core_clk), .lineIn(serialOutPin),
    .lineOut(serialInPin));
  initial begin
    forever #50 core_clk = ~core_clk;
  end
  // external source: one rising edge every two clocks
  always @(posedge core_clk) begin
    extClk <= ~extClk;
  end
  task automatic wrap_up;
    $display("compares %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chkR(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t %h %h", $time, got, exp);
    end
  endtask
  task automatic chkF(input logic [11:0] got, input logic [11:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t %h %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    busWrEn <= 1'b1;
    busAddr <= a;
    busWrData <= d;
    @(posedge core_clk);
    busWrEn <= 1'b0;
  endtask
  task automatic rc(input logic [3:0] a, input logic [7:0] e);
    @(posedge core_clk);
    busRdEn <= 1'b1;
    busAddr <= a;
    @(posedge core_clk);
    busRdEn <= 1'b0;
    #1 chkR(busRdData_r, e);
  endtask
  // line bits from start to stops, padded with idle ones
  function automatic logic [11:0] mkF(input logic [7:0] d,
      input logic [1:0] par, input logic l8);
    int nb;
    int p;
    mkF = 12'hfff;
    nb = l8 ? 8 : 7;
    mkF[0] = 1'b0;
    for (int i = 0; i < nb; i++) mkF[1 + i] = d[i];
    p = (par == 2'h2) ? 1 : 0;
    for (int i = 0; i < nb; i++) p = p ^ d[i];
    if (par == 2'h1) p = 0;
    if (par != 2'h0) mkF[1 + nb] = p[0];
  endfunction
  // fixed window: pulses are one cycle, so watch every cycle
  task automatic waitEv(input int bound);
    evDone = 1'b0;
    evErr = 1'b0;
    for (int i = 0; i < bound; i++) begin
      @(posedge core_clk);
      #1 evDone = evDone | rxDone_r;
      evErr = evErr | rxErr_r;
    end
  endtask
  task automatic getTx(input logic [11:0] e);
    for (int i = 0; i < 400 && rem.rxQ.size() == 0; i++)
      @(posedge core_clk);
    if (rem.rxQ.size() == 0) begin
      mismatches++;
      wrap_up;
    end else begin
      chkF(rem.rxQ.pop_front(), e);
    end
  endtask
  initial begin
    int t;
    int sp;
    logic [1:0] par;
    logic l8;
    logic [7:0] td;
    logic [7:0] rd8;
    logic [7:0] m;
    logic [2:0] st;
    void'($urandom(44025));
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    rc(4'h0, 8'h00);
    rc(4'h2, 8'h00);
    rc(4'h4, 8'h00);
    rc(4'h8, 8'h00);
    rc(4'ha, 8'hff);
    wr(4'ha, 8'h00);
    wr(4'h8, 8'h3c);
    rc(4'ha, 8'hff);
    rc(4'hc, 8'h00);
    chkR({7'h00, txBusy}, 8'h00);
    wr(4'h4, 8'h08);
    rc(4'h4, 8'h08);
    $display("test regs done");
    for (t = 0; t < 8; t++) begin
      par = t[1:0];
      l8 = 1'($urandom);
      td = 8'($urandom);
      rd8 = 8'($urandom);
      m = {2'h3, par, l8, 1'($urandom), t[2], 1'b0};
      wr(4'h0, m | 8'h01);
      rc(4'h0, m);
      sp = (l8 ? 8 : 7) + (par != 0) + 1;
      fr = mkF(rd8, par, l8);
      if (t >= 5) fr[sp - (t < 7)] = ~fr[sp - (t < 7)];
      st = {t == 6, t == 7, 1'b0};
      fork
        rem.send(fr);
        wr(4'h8, td);
        waitEv(1700);
      join
      getTx(mkF(td, par, l8));
      rc(4'h2, {5'h00, st});
      rc(4'ha, l8 ? rd8 : {1'b0, rd8[6:0]});
      chkR({evErr, evDone}, {st != 0, !(st != 0 && t[2])});
      $display("test %0d done", t);
    end
    wr(4'h0, 8'hc8);
    wr(4'h6, 8'h01);
    rem.bitLen = 256;
    td = 8'($urandom);
    rd8 = 8'($urandom);
    fork
      rem.send(mkF(rd8, 2'h0, 1'b1));
      wr(4'h8, td);
      waitEv(3400);
    join
    getTx(mkF(td, 2'h0, 1'b1));
    rc(4'ha, rd8);
    wr(4'h6, 8'h00);
    rem.bitLen = 128;
    $display("test external clock done");
    wr(4'h0, 8'h48);
    rem.send(mkF(8'h5a, 2'h0, 1'b1));
    rem.send(mkF(8'ha5, 2'h0, 1'b1));
    rc(4'h2, 8'h01);
    rc(4'ha, 8'ha5);
    wr(4'h0, 8'h00);
    rem.send(mkF(8'h11, 2'h0, 1'b1));
    rc(4'ha, 8'ha5);
    $display("test overrun done");
    wrap_up;
  end
endmodule // asp_serial_port_tb
